//--- design/ext_irq_pkg.sv
// package: register map, field positions, reset values and vectors of the external interrupt unit
package ext_irq_pkg;
  localparam logic [2:0] ADDR_SENSE   = 3'h0;
  localparam logic [2:0] ADDR_MASK    = 3'h1;
  localparam logic [2:0] ADDR_FLAGS   = 3'h2;
  localparam logic [2:0] ADDR_PCM_LO  = 3'h3;
  localparam logic [2:0] ADDR_PCM_HI  = 3'h4;
  localparam int BIT_SENSE_LO  = 0;
  localparam int BIT_SENSE_HI  = 1;
  localparam int BIT_EXT       = 6;
  localparam int BIT_GRP_HI    = 5;
  localparam int BIT_GRP_LO    = 4;
  localparam logic [7:0] MASK_USED    = 8'h70;
  localparam logic [1:0] SENSE_LEVEL  = 2'h0;
  localparam logic [1:0] SENSE_ANY    = 2'h1;
  localparam logic [1:0] SENSE_FALL   = 2'h2;
  localparam logic [1:0] SENSE_RISE   = 2'h3;
  localparam logic [1:0] RST_SENSE    = 2'h0;
  localparam logic [7:0] RST_REG      = 8'h00;
  localparam logic [3:0] RST_PCM_HI   = 4'h0;
  localparam logic [4:0] VEC_NONE     = 5'h00;
  localparam logic [4:0] VEC_EXT      = 5'h01;
  localparam logic [4:0] VEC_GRP_LO   = 5'h02;
  localparam logic [4:0] VEC_GRP_HI   = 5'h03;
endpackage

//--- design/external_pin_interrupt_unit.sv
// external pin and pin-change interrupt unit with register port and vector request
`timescale 1ns/1ps
module external_pin_interrupt_unit #(
  parameter int LO_LINES = 8,
  parameter int HI_LINES = 4
) (
  input  wire logic                clk_i,       // 20 MHz clock
  input  wire logic                reset_i,     // synchronous reset, high
  input  wire logic                clk_en_i,    // freezes all state when low
  input  wire logic                ext_irq_pin_i,    // dedicated interrupt pin level
  input  wire logic [LO_LINES+HI_LINES-1:0] pin_change_lines_i, // pin-change levels
  input  wire logic                global_irq_enable_i, // cpu global enable
  input  wire logic                vector_ack_i,  // cpu takes the vector on irq_vector_o
  input  wire logic [2:0]          addr_i,      // register address
  input  wire logic [7:0]          wdata_i,     // write data
  input  wire logic                write_i,     // write strobe
  input  wire logic                read_i,      // read strobe
  output logic [7:0]               rdata_o,     // read data, cycle after read
  output logic                     irq_o,       // interrupt request to cpu
  output logic [4:0]               irq_vector_o, // vector of highest request
  output logic                     pin_change_group_low_request_o, // low group pending
  output logic                     pin_change_group_high_request_o // high group pending
);
  // lines 0..LO_LINES-1 form the low group, the rest the high group
  localparam int NL = LO_LINES + HI_LINES;

  // ==========================================================
  // registers
  logic [1:0]          sense;
  logic                ext_en;
  logic                group_high_enable;
  logic                group_low_enable;
  logic [LO_LINES-1:0] pin_change_mask_low;
  logic [HI_LINES-1:0] pin_change_mask_high;
  logic                ext_pin_pending_flag;
  logic                group_high_pending_flag;
  logic                group_low_pending_flag;
  logic                ext_sample;
  logic [NL-1:0]       line_last;

  // every write is gated by the clock enable, so a frozen block ignores software too
  wire wr_sense = clk_en_i && write_i && addr_i == ext_irq_pkg::ADDR_SENSE;
  wire wr_mask  = clk_en_i && write_i && addr_i == ext_irq_pkg::ADDR_MASK;
  wire wr_flags = clk_en_i && write_i && addr_i == ext_irq_pkg::ADDR_FLAGS;
  wire wr_pclo  = clk_en_i && write_i && addr_i == ext_irq_pkg::ADDR_PCM_LO;
  wire wr_pchi  = clk_en_i && write_i && addr_i == ext_irq_pkg::ADDR_PCM_HI;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      sense                <= ext_irq_pkg::RST_SENSE;
      ext_en               <= 1'b0;
      group_high_enable    <= 1'b0;
      group_low_enable     <= 1'b0;
      pin_change_mask_low  <= '0;
      pin_change_mask_high <= '0;
    end
    else
    begin
      if (wr_sense)
        sense <= wdata_i[ext_irq_pkg::BIT_SENSE_HI:ext_irq_pkg::BIT_SENSE_LO];
      if (wr_mask)
      begin
        ext_en            <= wdata_i[ext_irq_pkg::BIT_EXT];
        group_high_enable <= wdata_i[ext_irq_pkg::BIT_GRP_HI];
        group_low_enable  <= wdata_i[ext_irq_pkg::BIT_GRP_LO];
      end
      if (wr_pclo)
        pin_change_mask_low <= wdata_i[LO_LINES-1:0];
      if (wr_pchi)
        pin_change_mask_high <= wdata_i[HI_LINES-1:0];
    end
  end

  // ==========================================================
  // pin observation
  // pins are read regardless of direction, so software driving them triggers too
  // the sampler starts high, the idle level, so reset never fakes a falling edge
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ext_sample <= 1'b1;
      line_last  <= '0;
    end
    else if (clk_en_i)
    begin
      ext_sample <= ext_irq_pin_i;
      line_last  <= pin_change_lines_i;
    end
  end

  logic [NL-1:0] line_hit;
  genvar g;
  generate
    for (g = 0; g < NL; g++)
    begin : g_line
      if (g < LO_LINES)
      begin : g_lo
        assign line_hit[g] = (pin_change_lines_i[g] ^ line_last[g]) && pin_change_mask_low[g];
      end
      else
      begin : g_hi
        assign line_hit[g] = (pin_change_lines_i[g] ^ line_last[g])
                             && pin_change_mask_high[g-LO_LINES];
      end
    end
  endgenerate

  // comparison is combinational on the raw lines, so a change is seen at the next edge
  wire lo_change = |line_hit[LO_LINES-1:0];
  wire hi_change = |line_hit[NL-1:LO_LINES];

  logic ext_edge;
  always_comb
  begin
    ext_edge = 1'b0;
    unique case (sense)
      ext_irq_pkg::SENSE_LEVEL: ext_edge = 1'b0;
      ext_irq_pkg::SENSE_ANY:   ext_edge = ext_irq_pin_i ^ ext_sample;
      ext_irq_pkg::SENSE_FALL:  ext_edge = ext_sample && !ext_irq_pin_i;
      ext_irq_pkg::SENSE_RISE:  ext_edge = !ext_sample && ext_irq_pin_i;
    endcase
  end
  wire level_mode = sense == ext_irq_pkg::SENSE_LEVEL;
  // low level acts straight from the pin: if it vanishes, no request remains
  wire level_req  = level_mode && !ext_irq_pin_i;

  // ==========================================================
  // pending flags: set wins over software and acknowledge clears
  // level forcing beats every set, since the flag must read zero in level mode
  // acknowledge clears only the flag of the vector the cpu actually took
  wire ack_ext = clk_en_i && vector_ack_i && irq_vector_o == ext_irq_pkg::VEC_EXT;
  wire ack_lo  = clk_en_i && vector_ack_i && irq_vector_o == ext_irq_pkg::VEC_GRP_LO;
  wire ack_hi  = clk_en_i && vector_ack_i && irq_vector_o == ext_irq_pkg::VEC_GRP_HI;

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      ext_pin_pending_flag    <= 1'b0;
      group_high_pending_flag <= 1'b0;
      group_low_pending_flag  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      if (level_mode)
        ext_pin_pending_flag <= 1'b0;
      else if (ext_edge)
        ext_pin_pending_flag <= 1'b1;
      else if (ack_ext || (wr_flags && wdata_i[ext_irq_pkg::BIT_EXT]))
        ext_pin_pending_flag <= 1'b0;
      if (hi_change)
        group_high_pending_flag <= 1'b1;
      else if (ack_hi || (wr_flags && wdata_i[ext_irq_pkg::BIT_GRP_HI]))
        group_high_pending_flag <= 1'b0;
      if (lo_change)
        group_low_pending_flag <= 1'b1;
      else if (ack_lo || (wr_flags && wdata_i[ext_irq_pkg::BIT_GRP_LO]))
        group_low_pending_flag <= 1'b0;
    end
  end

  // ==========================================================
  // request and vector, fixed priority by vector number
  // the trade: a busy low group can hold off the high group indefinitely
  wire ext_active = ext_en && (ext_pin_pending_flag || level_req);
  wire hi_active  = group_high_enable && group_high_pending_flag;
  wire lo_active  = group_low_enable && group_low_pending_flag;

  logic [4:0] next_vector;
  always_comb
  begin
    next_vector = ext_irq_pkg::VEC_NONE;
    if (global_irq_enable_i)
    begin
      if (ext_active)
        next_vector = ext_irq_pkg::VEC_EXT;
      else if (lo_active)
        next_vector = ext_irq_pkg::VEC_GRP_LO;
      else if (hi_active)
        next_vector = ext_irq_pkg::VEC_GRP_HI;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      irq_o                           <= 1'b0;
      irq_vector_o                    <= ext_irq_pkg::VEC_NONE;
      pin_change_group_low_request_o  <= 1'b0;
      pin_change_group_high_request_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      // a vector just acknowledged is dropped for one cycle to let its flag clear
      irq_o        <= (next_vector != ext_irq_pkg::VEC_NONE) && !vector_ack_i;
      irq_vector_o <= vector_ack_i ? ext_irq_pkg::VEC_NONE : next_vector;
      pin_change_group_low_request_o  <= lo_active;
      pin_change_group_high_request_o <= hi_active;
    end
  end

  // ==========================================================
  // read port
  // unmapped addresses read zero; data stand for one cycle only
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
      rdata_o <= ext_irq_pkg::RST_REG;
    else if (clk_en_i)
    begin
      rdata_o <= ext_irq_pkg::RST_REG;
      if (read_i)
      begin
        unique case (addr_i)
          ext_irq_pkg::ADDR_SENSE:  rdata_o <= {6'h00, sense};
          ext_irq_pkg::ADDR_MASK:   rdata_o <= {1'b0, ext_en, group_high_enable,
                                                group_low_enable, 4'h0};
          ext_irq_pkg::ADDR_FLAGS:  rdata_o <= {1'b0, ext_pin_pending_flag,
                                                group_high_pending_flag,
                                                group_low_pending_flag, 4'h0};
          ext_irq_pkg::ADDR_PCM_LO: rdata_o <= 8'(pin_change_mask_low);
          ext_irq_pkg::ADDR_PCM_HI: rdata_o <= 8'(pin_change_mask_high);
          default:                  rdata_o <= ext_irq_pkg::RST_REG;
        endcase
      end
    end
  end

  // ==========================================================
  // checks: dedicated pin, group flags, register read and global enable
  // edge checks look one cycle ahead; level mode is left out since it forces the flag low
  sequence s_fall_seen;
    ext_sample && !ext_irq_pin_i && sense == ext_irq_pkg::SENSE_FALL;
  endsequence
  sequence s_rise_seen;
    !ext_sample && ext_irq_pin_i && sense == ext_irq_pkg::SENSE_RISE;
  endsequence
  sequence s_any_seen;
    ext_sample != ext_irq_pin_i && sense == ext_irq_pkg::SENSE_ANY;
  endsequence
  sequence s_rise_in_fall;
    !ext_sample && ext_irq_pin_i && sense == ext_irq_pkg::SENSE_FALL;
  endsequence
  sequence s_level_live;
    clk_en_i && level_req && ext_en && global_irq_enable_i && !vector_ack_i;
  endsequence
  sequence s_level_acked;
    clk_en_i && level_req && ext_en && global_irq_enable_i && vector_ack_i;
  endsequence

  chk_fall_sets_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_fall_seen and clk_en_i) |=> ext_pin_pending_flag)
    else $error("falling edge did not set pin flag");
  chk_rise_sets_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_rise_seen and clk_en_i) |=> ext_pin_pending_flag)
    else $error("rising edge did not set pin flag");
  chk_any_sets_flag: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_any_seen and clk_en_i) |=> ext_pin_pending_flag)
    else $error("pin change did not set pin flag");
  chk_fall_not_rise: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_rise_in_fall and clk_en_i and !ext_pin_pending_flag) |=> !ext_pin_pending_flag)
    else $error("rising edge set flag in falling mode");
  chk_pin_flag_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && ext_pin_pending_flag && !level_mode && !vector_ack_i && !wr_flags
    |=> ext_pin_pending_flag)
    else $error("pin flag lost without a clear");
  // an acknowledge must not cancel a level that is still held low
  chk_level_persists: assert property (@(posedge clk_i) disable iff (reset_i)
    s_level_acked ##1 s_level_live |=> irq_o && irq_vector_o == ext_irq_pkg::VEC_EXT)
    else $error("held low level lost after acknowledge");
  chk_level_flag_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    $past(level_mode) && $past(clk_en_i) |-> !ext_pin_pending_flag)
    else $error("pin flag set in level mode");
  chk_level_request: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && level_req && ext_en && global_irq_enable_i && !vector_ack_i
    |=> irq_o && irq_vector_o == ext_irq_pkg::VEC_EXT)
    else $error("low level did not request vector one");
  chk_low_group_set: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && lo_change |=> group_low_pending_flag)
    else $error("low group change not flagged");
  chk_high_group_set: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && hi_change |=> group_high_pending_flag)
    else $error("high group change not flagged");
  chk_masked_line_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && pin_change_mask_low == '0 && !group_low_pending_flag
    |=> !group_low_pending_flag)
    else $error("masked lines set low group flag");
  chk_write_one_clears: assert property (@(posedge clk_i) disable iff (reset_i)
    wr_flags && wdata_i[ext_irq_pkg::BIT_GRP_HI] && !hi_change |=> !group_high_pending_flag)
    else $error("write one did not clear high flag");
  chk_reserved_zero: assert property (@(posedge clk_i) disable iff (reset_i)
    $past(read_i) && $past(clk_en_i) && ($past(addr_i) == ext_irq_pkg::ADDR_MASK
    || $past(addr_i) == ext_irq_pkg::ADDR_FLAGS) |-> (rdata_o & ~ext_irq_pkg::MASK_USED) == 8'h00)
    else $error("reserved bits read nonzero");
  chk_no_global_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && !global_irq_enable_i |=> !irq_o)
    else $error("request without global enable");

  // ==========================================================
  // checks: pin-change groups and vector
  sequence s_ack_low;
    clk_en_i && vector_ack_i && irq_vector_o == ext_irq_pkg::VEC_GRP_LO;
  endsequence
  sequence s_ack_high;
    clk_en_i && vector_ack_i && irq_vector_o == ext_irq_pkg::VEC_GRP_HI;
  endsequence

  chk_masked_high_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && pin_change_mask_high == '0 && !group_high_pending_flag
    |=> !group_high_pending_flag)
    else $error("masked lines set high group flag");
  chk_ack_clears_low: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_ack_low and !lo_change) |=> !group_low_pending_flag)
    else $error("acknowledge did not clear low flag");
  chk_ack_clears_high: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_ack_high and !hi_change) |=> !group_high_pending_flag)
    else $error("acknowledge did not clear high flag");
  // a pending group stays pending until software or the cpu clears it
  chk_low_flag_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && group_low_pending_flag && !vector_ack_i && !wr_flags
    |=> group_low_pending_flag)
    else $error("low group flag lost without a clear");
  chk_ack_drops_irq: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && vector_ack_i |=> !irq_o && irq_vector_o == ext_irq_pkg::VEC_NONE)
    else $error("request not dropped after acknowledge");
  chk_low_vector: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && global_irq_enable_i && lo_active && !ext_active && !vector_ack_i
    |=> irq_o && irq_vector_o == ext_irq_pkg::VEC_GRP_LO)
    else $error("low group not on vector two");
  chk_high_vector: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && global_irq_enable_i && hi_active && !lo_active && !ext_active
    && !vector_ack_i |=> irq_o && irq_vector_o == ext_irq_pkg::VEC_GRP_HI)
    else $error("high group not on vector three");
  chk_low_out_on: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && group_low_enable && group_low_pending_flag
    |=> pin_change_group_low_request_o)
    else $error("low group request output missing");
  chk_low_out_off: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && !group_low_enable |=> !pin_change_group_low_request_o)
    else $error("low group request without enable");
  chk_high_out_on: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && group_high_enable && group_high_pending_flag
    |=> pin_change_group_high_request_o)
    else $error("high group request output missing");
  chk_high_out_off: assert property (@(posedge clk_i) disable iff (reset_i)
    clk_en_i && !group_high_enable |=> !pin_change_group_high_request_o)
    else $error("high group request without enable");
endmodule

//--- testbench/pin_source.sv
// far-side model: external sources driving the dedicated pin and the pin-change lines
`timescale 1ns/1ps
module pin_source (
  input  wire logic        clk_i,              // bench clock
  input  wire logic        ext_level_i,        // wanted level of the dedicated pin
  input  wire logic [11:0] toggle_i,           // one-cycle request to toggle lines
  output logic             ext_irq_pin_o,      // dedicated pin
  output logic [11:0]      pin_change_lines_o  // pin-change lines
);
  // ==========================================================================
  // pin drivers
  // levels are held for whole clocks, never narrower than one period
  initial
  begin
    ext_irq_pin_o = 1'b1;
    pin_change_lines_o = 12'h000;
  end
  always @(posedge clk_i)
  begin
    ext_irq_pin_o <= ext_level_i;
    pin_change_lines_o <= pin_change_lines_o ^ toggle_i;
  end
endmodule

//--- testbench/test_external_pin_interrupt_unit.sv
// self-checking bench of the external pin interrupt unit
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
  $display("ERROR %0t: got %h expected %h", $time, a, b); end end
module test_external_pin_interrupt_unit;
  // ==========================================================================
  // signals
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        ext_level = 1'b1;
  logic [11:0] toggle = 12'h000;
  logic        ext_irq_pin;
  logic [11:0] lines;
  logic        genable = 1'b0;
  logic        ack = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        write = 1'b0;
  logic        read = 1'b0;
  logic [7:0]  rdata;
  logic        irq;
  logic [4:0]  vec;
  logic        lo_req;
  logic        hi_req;
  logic        clk_en = 1'b1;
  int          n_fail = 0;
  int          compares = 0;
  logic [7:0]  d;

  initial
  begin
    forever #25 clk_i = ~clk_i;
  end

  pin_source src (.clk_i(clk_i), .ext_level_i(ext_level), .toggle_i(toggle),
    .ext_irq_pin_o(ext_irq_pin), .pin_change_lines_o(lines));
  external_pin_interrupt_unit dut (.clk_i(clk_i), .reset_i(reset_i), .clk_en_i(clk_en),
    .ext_irq_pin_i(ext_irq_pin), .pin_change_lines_i(lines), .global_irq_enable_i(genable),
    .vector_ack_i(ack), .addr_i(addr), .wdata_i(wdata), .write_i(write), .read_i(read),
    .rdata_o(rdata), .irq_o(irq), .irq_vector_o(vec),
    .pin_change_group_low_request_o(lo_req), .pin_change_group_high_request_o(hi_req));

  // ==========================================================================
  // bus and helper tasks
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr <= a; wdata <= v; write <= 1'b1;
    @(posedge clk_i);
    write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr <= a; read <= 1'b1;
    @(posedge clk_i);
    read <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic pin(input logic lvl);
    @(posedge clk_i);
    ext_level <= lvl;
    wait_cyc(5);
  endtask
  task automatic flip(input logic [11:0] t);
    @(posedge clk_i);
    toggle <= t;
    @(posedge clk_i);
    toggle <= 12'h000;
    wait_cyc(4);
  endtask
  function automatic logic ext_hit(input logic [1:0] mode, input logic rise);
    return (mode == ext_irq_pkg::SENSE_ANY) || (mode == ext_irq_pkg::SENSE_RISE && rise)
      || (mode == ext_irq_pkg::SENSE_FALL && !rise);
  endfunction

  // one group: masked-out line ignored, masked-in line flags, ack and write-one clear
  task automatic group(input int hi);
    int         n;
    int         i;
    int         j;
    int         b;
    logic [7:0] m;
    n = hi ? 4 : 8;
    b = hi ? ext_irq_pkg::BIT_GRP_HI : ext_irq_pkg::BIT_GRP_LO;
    i = $urandom % n;
    j = (i + 1 + $urandom % (n - 1)) % n;
    m = (8'($urandom) | (8'h01 << i)) & ~(8'h01 << j);
    if (hi) m = m & 8'h0f;
    wr(hi ? ext_irq_pkg::ADDR_PCM_HI : ext_irq_pkg::ADDR_PCM_LO, m);
    wr(ext_irq_pkg::ADDR_MASK, 8'h01 << b);
    flip(12'h001 << (j + 8 * hi));
    rd(ext_irq_pkg::ADDR_FLAGS, d); `CHK(d, 8'h00)
    flip(12'h001 << (i + 8 * hi));
    rd(ext_irq_pkg::ADDR_FLAGS, d); `CHK(d, 8'h01 << b)
    `CHK(irq, 1'b1)
    `CHK(vec, hi ? ext_irq_pkg::VEC_GRP_HI : ext_irq_pkg::VEC_GRP_LO)
    `CHK({hi_req, lo_req}, hi ? 2'h2 : 2'h1)
    @(posedge clk_i);
    ack <= 1'b1;
    @(posedge clk_i);
    ack <= 1'b0;
    wait_cyc(2);
    `CHK(irq, 1'b0)
    `CHK({hi_req, lo_req}, 2'h0)
    rd(ext_irq_pkg::ADDR_FLAGS, d); `CHK(d, 8'h00)
    flip(12'h001 << (i + 8 * hi));
    wr(ext_irq_pkg::ADDR_FLAGS, 8'h01 << b);
    rd(ext_irq_pkg::ADDR_FLAGS, d); `CHK(d, 8'h00)
    $display("group %0d test done", hi);
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // watchdog
  initial
  begin
    wait_cyc(4000);
    n_fail++;
    end_of_test;
  end

  // ==========================================================================
  // main sequence
  initial
  begin
    void'($urandom(32'ha6a4760b));
    wait_cyc(4);
    reset_i <= 1'b0;
    for (int a = 0; a < 6; a++)
    begin
      rd(3'(a), d); `CHK(d, 8'h00)
    end
    wr(ext_irq_pkg::ADDR_MASK, 8'hff);
    rd(ext_irq_pkg::ADDR_MASK, d); `CHK(d, ext_irq_pkg::MASK_USED)
    wr(3'h5, 8'hff);
    rd(3'h5, d); `CHK(d, 8'h00)
    $display("register test done");
    @(posedge clk_i);
    genable <= 1'b1;
    group(0);
    group(1);
    for (int m = 1; m < 4; m++)
    begin
      wr(ext_irq_pkg::ADDR_SENSE, 8'(m));
      for (int r = 0; r < 2; r++)
      begin
        pin(r[0] ? 1'b0 : 1'b1);
        wr(ext_irq_pkg::ADDR_FLAGS, 8'hff);
        pin(r[0]);
        rd(ext_irq_pkg::ADDR_FLAGS, d);
        `CHK(d, ext_hit(2'(m), r[0]) ? 8'h40 : 8'h00)
      end
    end
    $display("edge sense test done");
    wr(ext_irq_pkg::ADDR_MASK, 8'h50);
    wr(ext_irq_pkg::ADDR_SENSE, {6'h00, ext_irq_pkg::SENSE_LEVEL});
    pin(1'b0);
    `CHK(irq, 1'b1)
    `CHK(vec, ext_irq_pkg::VEC_EXT)
    rd(ext_irq_pkg::ADDR_FLAGS, d); `CHK(d, 8'h00)
    wr(ext_irq_pkg::ADDR_PCM_LO, 8'h01);
    flip(12'h001);
    `CHK(vec, ext_irq_pkg::VEC_EXT)
    genable <= 1'b0;
    wait_cyc(3);
    `CHK(irq, 1'b0)
    genable <= 1'b1;
    pin(1'b1);
    `CHK(irq, 1'b1)
    `CHK(vec, ext_irq_pkg::VEC_GRP_LO)
    $display("level sense test done");
    clk_en <= 1'b0;
    wr(ext_irq_pkg::ADDR_SENSE, 8'h03);
    clk_en <= 1'b1;
    rd(ext_irq_pkg::ADDR_SENSE, d); `CHK(d, 8'h00)
    $display("freeze test done");
    end_of_test;
  end
endmodule
